// File: shared/tmc_pkg.sv
/*
 Package for the 16-bit timer control block: register offsets, field
 positions, reset values, mode and clock-source codes, shared structs.
 Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package tmc_pkg;

   // ***************************************************************
   // Register map (printed offsets not multiples of four: indices)
   // ***************************************************************
   localparam logic [7:0]  IDX_CTRL_A     = 8'h80;
   localparam logic [7:0]  IDX_CTRL_B     = 8'h81;
   localparam logic [7:0]  IDX_STATUS     = 8'h90;
   localparam logic [7:0]  IDX_MASK       = 8'h91;
   localparam logic [7:0]  IDX_CAPTURE    = 8'h92;
   localparam logic [7:0]  IDX_COUNT      = 8'h93;
   localparam logic [7:0]  IDX_COMPARE_A  = 8'h94;
   localparam logic [7:0]  IDX_COMPARE_C  = 8'h95;

   localparam logic [7:0]  RST_CTRL_A     = 8'h00;
   localparam logic [7:0]  RST_CTRL_B     = 8'h00;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int          POS_A_ACT_C    = 2;
   localparam int          POS_A_MODE_LO  = 0;
   localparam int          POS_B_FILT     = 7;
   localparam int          POS_B_EDGE     = 6;
   localparam int          POS_B_RSVD     = 5;
   localparam int          POS_B_MODE_HI  = 3;
   localparam int          POS_B_CLK      = 0;
   localparam int          ST_CAPTURE     = 0;
   localparam int          ST_MATCH_C     = 1;
   localparam int          ST_OVERFLOW    = 2;

   // ***************************************************************
   // Timing and codes
   // ***************************************************************
   localparam int          FILTER_SAMPLES = 4;
   localparam logic [9:0]  DIV_8_MASK     = 10'h007;
   localparam logic [9:0]  DIV_64_MASK    = 10'h03f;
   localparam logic [9:0]  DIV_256_MASK   = 10'h0ff;
   localparam logic [9:0]  DIV_1024_MASK  = 10'h3ff;

   localparam logic [3:0]  MODE_NORMAL    = 4'h0;
   localparam logic [3:0]  MODE_CLR_A     = 4'h4;
   localparam logic [3:0]  MODE_PFC_CAP   = 4'h8;
   localparam logic [3:0]  MODE_PC_CAP    = 4'ha;
   localparam logic [3:0]  MODE_CLR_A2    = 4'hc;
   localparam logic [3:0]  MODE_RESERVED  = 4'hd;
   localparam logic [3:0]  MODE_FAST_CAP  = 4'he;

   typedef enum logic [2:0] {
      CLK_STOP  = 3'h0,
      CLK_DIV1  = 3'h1,
      CLK_DIV8  = 3'h2,
      CLK_DIV64 = 3'h3,
      CLK_DIV256 = 3'h4,
      CLK_DIV1024 = 3'h5,
      CLK_EXT_FALL = 3'h6,
      CLK_EXT_RISE = 3'h7
   } tmc_clk_src_t;

   typedef enum logic [1:0] {
      ACT_OFF    = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_CLEAR  = 2'h2,
      ACT_SET    = 2'h3
   } tmc_action_t;

   // Capture filter machine, one-hot
   typedef enum logic [1:0] {
      FLT_LOW  = 2'b01,
      FLT_HIGH = 2'b10
   } tmc_filt_t;

   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [2:0]  status;
      logic [2:0]  mask;
      logic [15:0] count;
      logic [15:0] capture;
      logic [15:0] compare_a;
      logic [15:0] compare_c;
      logic [9:0]  prescale;
      logic [1:0]  cap_sync;
      logic [1:0]  ext_sync;
      logic        ext_prev;
      logic [2:0]  flt_run;
      tmc_filt_t   flt_state;
      logic        cap_prev;
      logic        out_c;
      logic [31:0] prdata;
   } tmc_state_t;

endpackage

// File: logic/tmc_timer_ctrl.sv
/*
 16-bit timer control block: mode and clock selection, channel C output
 action, input capture with noise filter, APB register access and one
 level interrupt. Assumes pins arrive asynchronous and that the port
 logic outside honours the pin output enable it gets from here.
*/
//
// Functional notes
// RULE1 - Outside PWM modes the channel C action is off, toggle, clear or set on match.
// RULE2 - A nonzero channel C action hands the pin to the compare output.
// RULE3 - Software sets the pin direction to output before the waveform drives it.
// RULE4 - The mode low bits sit in control A bits 1:0 and high bits in control B bits 4:3.
// RULE5 - Modes 0 to 7 are normal, phase PWM 8/9/10, clear on compare A, fast PWM 8/9/10.
// RULE6 - Modes 8 to 15 give PFC, phase and fast PWM with capture or compare A top; 13 reserved; the code runs 12 as clear on compare A, not PWM.
// RULE7 - With the filter on, the capture input changes after four equal samples.
// RULE8 - Edge polarity zero captures on falling edges, one on rising edges.
// RULE9 - A capture edge copies the counter into the capture register and sets the flag.
// RULE10 - Modes using the capture register as top disconnect the pin and block capture.
// RULE11 - Control B bit 5 reads zero and ignores writes.
// RULE12 - Clock source 0 stops, 1 counts every clock, 2 to 5 divide by 8, 64, 256, 1024.
// RULE13 - Clock source 6 counts falling and 7 rising edges of the external count pin.
// RULE14 - External edges count even when that pin is driven as an output.
// RULE15 - The external count pin is synchronised and edge detected into a one-cycle enable.
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_ctrl
   import tmc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_input_pin,
   input  wire logic        external_count_pin,
   input  wire logic        chan_c_pin_dir,
   output logic             chan_c_compare_pin,
   output logic             chan_c_compare_pin_oe,
   output logic             capture_pin_connected,
   output logic             count_tick,
   output logic             irq
);

   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   function automatic logic top_is_capture(input logic [3:0] m);
      top_is_capture = (m == MODE_PFC_CAP) || (m == MODE_PC_CAP) || (m == MODE_FAST_CAP);
   endfunction

   function automatic logic non_pwm(input logic [3:0] m);
      non_pwm = (m == MODE_NORMAL) || (m == MODE_CLR_A) || (m == MODE_CLR_A2);
   endfunction

   function automatic logic [15:0] top_value(input logic [3:0] m,
                                             input logic [15:0] cap,
                                             input logic [15:0] cmp_a);
      case (m)
         4'h1, 4'h5:                  top_value = 16'h00ff;
         4'h2, 4'h6:                  top_value = 16'h01ff;
         4'h3, 4'h7:                  top_value = 16'h03ff;
         4'h4, 4'h9, 4'hb, 4'hc, 4'hf: top_value = cmp_a;
         4'h8, 4'ha, 4'he:            top_value = cap;
         default:                     top_value = 16'hffff;
      endcase
   endfunction

   tmc_state_t      s;
   tmc_state_t      next_s;
   logic      [3:0] wave_mode;
   logic            wr_en;
   logic            rd_en;
   logic      [9:0] word_idx;
   logic            hit;
   logic            tick;
   logic            flt_in;
   logic            cap_edge;
   logic            match_c;
   logic      [15:0] top;

   // ***************************************************************
   // Bus access
   // ***************************************************************
   // Zero wait states; unaligned or unmapped words raise pslverr
   assign pready    = 1'b1;
   assign wr_en     = psel && penable && pwrite;
   assign rd_en     = psel && !penable && !pwrite;
   assign word_idx  = paddr[11:2];
   assign wave_mode = {s.ctrl_b[POS_B_MODE_HI +: 2], s.ctrl_a[POS_A_MODE_LO +: 2]}; // RULE4
   assign top       = top_value(wave_mode, s.capture, s.compare_a); // RULE5 RULE6

   always_comb begin
      case (word_idx[7:0])
         IDX_CTRL_A, IDX_CTRL_B, IDX_STATUS, IDX_MASK,
         IDX_CAPTURE, IDX_COUNT, IDX_COMPARE_A, IDX_COMPARE_C: hit = (word_idx[9:8] == 2'b00);
         default:                                              hit = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && (!hit || (paddr[1:0] != 2'b00));

   // ***************************************************************
   // Clock source
   // ***************************************************************
   always_comb begin
      case (tmc_clk_src_t'(s.ctrl_b[POS_B_CLK +: 3]))          // RULE12 RULE13
         CLK_STOP:     tick = 1'b0;
         CLK_DIV1:     tick = 1'b1;
         CLK_DIV8:     tick = (s.prescale & DIV_8_MASK) == DIV_8_MASK;
         CLK_DIV64:    tick = (s.prescale & DIV_64_MASK) == DIV_64_MASK;
         CLK_DIV256:   tick = (s.prescale & DIV_256_MASK) == DIV_256_MASK;
         CLK_DIV1024:  tick = (s.prescale & DIV_1024_MASK) == DIV_1024_MASK;
         // Pin is sampled regardless of its direction
         CLK_EXT_FALL: tick = s.ext_prev && !s.ext_sync[1];    // RULE14 RULE15
         CLK_EXT_RISE: tick = !s.ext_prev && s.ext_sync[1];    // RULE14 RULE15
         default:      tick = 1'b0;
      endcase
   end

   // ***************************************************************
   // Capture path
   // ***************************************************************
   // Filtered level is the one-hot filter state; raw level otherwise
   assign flt_in   = s.ctrl_b[POS_B_FILT] ? (s.flt_state == FLT_HIGH) : s.cap_sync[1]; // RULE7
   assign cap_edge = !top_is_capture(wave_mode) &&                                     // RULE10
                     (s.ctrl_b[POS_B_EDGE] ? (flt_in && !s.cap_prev)                   // RULE8
                                           : (!flt_in && s.cap_prev));
   assign match_c  = tick && (s.count == s.compare_c);

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      next_s = s;
      next_s.cap_sync = {s.cap_sync[0], capture_input_pin};
      next_s.ext_sync = {s.ext_sync[0], external_count_pin};
      next_s.ext_prev = s.ext_sync[1];
      next_s.prescale = s.prescale + 10'h001;
      next_s.cap_prev = flt_in;

      // Four equal samples of the new level move the filter
      case (s.flt_state)
         FLT_LOW: begin
            next_s.flt_run = s.cap_sync[1] ? s.flt_run + 3'h1 : 3'h0;
            if (s.cap_sync[1] && (s.flt_run == 3'(FILTER_SAMPLES - 1))) begin // RULE7
               next_s.flt_state = FLT_HIGH;
               next_s.flt_run   = 3'h0;
            end
         end
         FLT_HIGH: begin
            next_s.flt_run = !s.cap_sync[1] ? s.flt_run + 3'h1 : 3'h0;
            if (!s.cap_sync[1] && (s.flt_run == 3'(FILTER_SAMPLES - 1))) begin // RULE7
               next_s.flt_state = FLT_LOW;
               next_s.flt_run   = 3'h0;
            end
         end
         default: begin
            next_s.flt_state = FLT_LOW;
            next_s.flt_run   = 3'h0;
         end
      endcase

      // Counter: up to top then wrap; PWM slopes are beyond this block
      if (tick) begin
         if (s.count >= top) begin
            next_s.count = 16'h0000;
            next_s.status[ST_OVERFLOW] = 1'b1;
         end else begin
            next_s.count = s.count + 16'h0001;
         end
      end

      if (match_c) begin
         next_s.status[ST_MATCH_C] = 1'b1;
         if (non_pwm(wave_mode)) begin
            case (tmc_action_t'(s.ctrl_a[POS_A_ACT_C +: 2]))   // RULE1
               ACT_TOGGLE: next_s.out_c = !s.out_c;
               ACT_CLEAR:  next_s.out_c = 1'b0;
               ACT_SET:    next_s.out_c = 1'b1;
               default:    next_s.out_c = s.out_c;
            endcase
         end
      end

      // Bus writes; status clears by one, events below win
      if (wr_en && hit && (paddr[1:0] == 2'b00)) begin
         case (word_idx[7:0])
            IDX_CTRL_A:    next_s.ctrl_a = pwdata[7:0];
            IDX_CTRL_B: begin
               next_s.ctrl_b = pwdata[7:0];
               next_s.ctrl_b[POS_B_RSVD] = 1'b0;                // RULE11
            end
            IDX_STATUS:    next_s.status = s.status & ~pwdata[2:0];
            IDX_MASK:      next_s.mask = pwdata[2:0];
            IDX_COUNT:     next_s.count = pwdata[15:0];
            IDX_COMPARE_A: next_s.compare_a = pwdata[15:0];
            IDX_COMPARE_C: next_s.compare_c = pwdata[15:0];
            default:       next_s.mask = s.mask;
         endcase
      end
      if (match_c) begin
         next_s.status[ST_MATCH_C] = 1'b1;
      end
      if (tick && (s.count >= top)) begin
         next_s.status[ST_OVERFLOW] = 1'b1;
      end
      if (cap_edge) begin
         next_s.capture = s.count;                              // RULE9
         next_s.status[ST_CAPTURE] = 1'b1;                      // RULE9
      end

      // Read data latched in setup so it comes from a flip-flop
      if (rd_en) begin
         case (word_idx[7:0])
            IDX_CTRL_A:    next_s.prdata = {24'h000000, s.ctrl_a};
            IDX_CTRL_B:    next_s.prdata = {24'h000000, s.ctrl_b};
            IDX_STATUS:    next_s.prdata = {29'h00000000, s.status};
            IDX_MASK:      next_s.prdata = {29'h00000000, s.mask};
            IDX_CAPTURE:   next_s.prdata = {16'h0000, s.capture};
            IDX_COUNT:     next_s.prdata = {16'h0000, s.count};
            IDX_COMPARE_A: next_s.prdata = {16'h0000, s.compare_a};
            IDX_COMPARE_C: next_s.prdata = {16'h0000, s.compare_c};
            default:       next_s.prdata = 32'h00000000;
         endcase
         if (word_idx[9:8] != 2'b00) begin
            next_s.prdata = 32'h00000000;
         end
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s           <= '0;
         s.ctrl_a    <= RST_CTRL_A;
         s.ctrl_b    <= RST_CTRL_B;
         s.flt_state <= FLT_LOW;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign prdata                = s.prdata;
   assign chan_c_compare_pin    = s.out_c;
   // Pin only driven when software also set its direction
   assign chan_c_compare_pin_oe = (s.ctrl_a[POS_A_ACT_C +: 2] != 2'b00) && chan_c_pin_dir; // RULE2 RULE3
   assign capture_pin_connected = !top_is_capture(wave_mode);   // RULE10
   assign count_tick            = tick;
   assign irq                   = |(s.status & s.mask);

endmodule
`default_nettype wire

// File: tb/tmc_timer_chk_sva.sv
/*
 Assertion checker for the timer control block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_chk
   import tmc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        external_count_pin,
   input wire logic        chan_c_pin_dir,
   input wire logic        chan_c_compare_pin_oe,
   input wire logic        capture_pin_connected,
   input wire logic        count_tick
);
   // ****************
   // Control shadows
   // ****************
   // Shadows follow completed writes, so fields are seen as the block sees them
   logic [7:0] sa;
   logic [7:0] sb;
   logic [3:0] md;
   logic [2:0] src;
   logic       wr;
   assign wr  = psel & penable & pwrite & pready;
   assign md  = {sb[4:3], sa[1:0]};
   assign src = sb[2:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sa <= 8'h00;
         sb <= 8'h00;
      end else if (wr && paddr == {2'h0, IDX_CTRL_A, 2'h0}) begin
         sa <= pwdata[7:0];
      end else if (wr && paddr == {2'h0, IDX_CTRL_B, 2'h0}) begin
         sb <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************
   // Assertions
   // ****************
   AST_OE_ACTION: assert property (
      chan_c_compare_pin_oe == ((sa[3:2] != 2'h0) && chan_c_pin_dir))
      else $error("compare pin enable wrong");
   AST_CAP_DISC: assert property (
      capture_pin_connected == !(md == MODE_PFC_CAP || md == MODE_PC_CAP || md == MODE_FAST_CAP))
      else $error("capture pin connection wrong");
   AST_STOP: assert property (src == 3'h0 |-> !count_tick)
      else $error("tick while stopped");
   AST_DIV1: assert property (src == 3'h1 && $past(src) == 3'h1 |-> count_tick)
      else $error("missing tick at full rate");
   AST_DIV8_GAP: assert property (
      src == 3'h2 && count_tick |=> (!count_tick || src != 3'h2) [*7])
      else $error("divide by 8 tick too early");
   AST_EXT_PULSE: assert property (src[2:1] == 2'h3 && count_tick |=> !count_tick)
      else $error("external tick longer than one cycle");
   AST_EXT_RISE: assert property (
      src == 3'h7 && $past(src, 3) == 3'h7 && count_tick |->
      $past(external_count_pin, 2) && !$past(external_count_pin, 3))
      else $error("rising tick without rising pin");
   AST_EXT_FALL: assert property (
      src == 3'h6 && $past(src, 3) == 3'h6 && count_tick |->
      !$past(external_count_pin, 2) && $past(external_count_pin, 3))
      else $error("falling tick without falling pin");
   AST_RSVD_READ: assert property (
      psel && penable && !pwrite && paddr == {2'h0, IDX_CTRL_B, 2'h0} |-> !prdata[5])
      else $error("reserved bit read as one");
   AST_READY: assert property (psel && penable |-> pready)
      else $error("access not answered");
   COV_EXT: cover property (src == 3'h7 && count_tick);
   COV_DIV: cover property (src == 3'h5 && count_tick);
   COV_ERR: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
 Self-checking bench for the timer control block over APB.
 Assumes the checker is compiled alongside and bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import tmc_pkg::*;
;
   // ****************
   // Signals
   // ****************
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        cap = 0, ext = 0, dir = 0, pin, oe, conn, tick, irq, pready, pslverr, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   int          miscompares = 0, n_checks = 0, ticks = 0, ch;
   int          sh[6] = '{0, 0, 3, 6, 8, 10};
   logic        prev;
   tmc_timer_ctrl tmc_timer_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .capture_input_pin(cap), .external_count_pin(ext),
      .chan_c_pin_dir(dir), .chan_c_compare_pin(pin), .chan_c_compare_pin_oe(oe),
      .capture_pin_connected(conn), .count_tick(tick), .irq);
   always #5 pclk = ~pclk;
   always @(posedge pclk) if (tick === 1'b1) ticks++;
   // ****************
   // Tasks
   // ****************
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task close_out;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Holds the request until pready is sampled high; bounded wait
   task xf(input logic w, input logic [7:0] ix, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'h0, ix, 2'h0}; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 40);
      q = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
      if (pready !== 1'b1) begin miscompares++; close_out; end
   endtask
   task wt(input int n); repeat (n) @(posedge pclk); endtask
   // ****************
   // Sequence
   // ****************
   initial begin
      wt(6); presetn <= 1;
      xf(0, IDX_CTRL_A, 0); chk("ctrl_a reset", q, {24'h0, RST_CTRL_A});
      xf(0, IDX_CTRL_B, 0); chk("ctrl_b reset", q, {24'h0, RST_CTRL_B});
      xf(1, IDX_CTRL_B, 32'hff); xf(0, IDX_CTRL_B, 0); chk("ctrl_b rsvd", q, 32'hdf);
      xf(0, 8'hff, 0); chk("unmapped err", err, 1); chk("unmapped data", q, 0);
      for (int m = 0; m < 16; m++) begin
         xf(1, IDX_CTRL_A, m & 3); xf(1, IDX_CTRL_B, (m >> 2) << 3);
         xf(0, IDX_CTRL_A, 0); chk("mode low", q, m & 3);
         xf(0, IDX_CTRL_B, 0); chk("mode high", q, (m >> 2) << 3);
         chk("cap connected", conn, !(m == 8 || m == 10 || m == 14));
      end
      xf(1, IDX_CTRL_A, 0);
      for (int s = 0; s < 6; s++) begin
         xf(1, IDX_CTRL_B, s); #1 ticks = 0; wt(2048);
         #1 chk("tick count", ticks, s ? 2048 >> sh[s] : 0);
      end
      for (int s = 6; s < 8; s++) begin
         xf(1, IDX_CTRL_B, s); #1 ticks = 0;
         repeat (5) begin @(posedge pclk); ext <= 1; wt(4); ext <= 0; wt(4); end
         #1 chk("ext ticks", ticks, 5);
      end
      xf(1, IDX_CTRL_B, 0); xf(1, IDX_COUNT, 32'h1234); xf(1, IDX_STATUS, 7);
      @(posedge pclk); cap <= 1; wt(10);
      xf(0, IDX_STATUS, 0); chk("rise ignored", q[0], 0);
      @(posedge pclk); cap <= 0; wt(10);
      xf(0, IDX_STATUS, 0); chk("fall flag", q[0], 1); chk("irq masked", irq, 0);
      xf(0, IDX_CAPTURE, 0); chk("capture", q, 32'h1234);
      xf(1, IDX_MASK, 1); #1 chk("irq set", irq, 1);
      xf(1, IDX_STATUS, 1); #1 chk("irq clear", irq, 0); xf(0, IDX_STATUS, 0); chk("flag clr", q[0], 0);
      xf(1, IDX_CTRL_B, 32'hc0); xf(1, IDX_COUNT, 32'habc);
      @(posedge pclk); cap <= 1; wt(3); cap <= 0; wt(10);
      xf(0, IDX_STATUS, 0); chk("short pulse", q[0], 0);
      @(posedge pclk); cap <= 1; wt(8);
      xf(0, IDX_STATUS, 0); chk("filtered flag", q[0], 1);
      xf(0, IDX_CAPTURE, 0); chk("filtered cap", q, 32'habc);
      xf(1, IDX_STATUS, 1); xf(1, IDX_CTRL_A, 2); xf(1, IDX_CTRL_B, 32'h58);
      @(posedge pclk); cap <= 0; wt(8); cap <= 1; wt(10);
      xf(0, IDX_STATUS, 0); chk("top blocks cap", q[0], 0);
      xf(1, IDX_COMPARE_A, 15); xf(1, IDX_COMPARE_C, 5); xf(1, IDX_COUNT, 0);
      xf(1, IDX_CTRL_B, 32'h09); dir <= 1;
      for (int a = 3; a > 0; a--) begin
         xf(1, IDX_CTRL_A, a << 2); #1 chk("pin oe", oe, 1);
         ch = 0; prev = pin;
         repeat (40) begin @(posedge pclk); if (pin !== prev) ch++; prev = pin; end
         chk("action", a == 1 ? (ch >= 2) : pin, a == 3 || a == 1);
      end
      xf(1, IDX_CTRL_A, 0); #1 chk("pin released", oe, 0);
      xf(1, IDX_CTRL_A, 32'h0c); dir <= 0; #1 chk("pin dir gate", oe, 0);
      close_out;
   end
endmodule
bind tmc_timer_ctrl tmc_timer_chk tmc_timer_chk_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_count_pin,
   .chan_c_pin_dir, .chan_c_compare_pin_oe, .capture_pin_connected, .count_tick);
`default_nettype wire
